// *** irs_slave.sv ***
`timescale 1ns/1ps
module irs_slave import irs_pkg::*; #(
    parameter logic [NREG*8-1:0] FACTORY_DEF = '0,
    parameter logic [NREG*8-1:0] RSVD_MASK   = {NREG{8'hff}}
) (
    input  wire logic              I_CORE_CLK,
    input  wire logic              I_RST_B,
    input  wire logic              I_SCL,
    input  wire logic              I_SDA,
    input  wire logic              I_OTP_VALID,
    input  wire logic [NREG*8-1:0] I_OTP_DEF,
    output logic                   O_SDA_OUT,
    output logic                   O_SDA_OE_B,
    output logic                   O_BUSY,
    output logic                   O_WR_STB,
    output logic [6:0]             O_DEV_ADDR,
    output logic [NREG*8-1:0]      O_REGS
);
    // ---- link domain: sample data on each rising bus clock
    logic       lk_bit_q;
    logic       lk_tgl_q;

    // bit sampled with clock high, toggle marks a new bit
    always_ff @(posedge I_SCL or negedge I_RST_B) begin
        if (!I_RST_B) begin
            lk_bit_q <= 1'b0;
            lk_tgl_q <= 1'b0;
        end else begin
            lk_bit_q <= I_SDA;
            lk_tgl_q <= ~lk_tgl_q;
        end
    end

    // ---- core domain synchronisers: clock, data, bit toggle
    logic [2:0] sy_m_q;
    logic [2:0] sy_s_q;
    logic [2:0] sy_p_q;

    // two flops per line, third for edges; 100x oversampled
    always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            sy_m_q <= 3'h6; // lines idle high, toggle as after reset
            sy_s_q <= 3'h6;
            sy_p_q <= 3'h6;
        end else begin
            sy_m_q <= {I_SCL, I_SDA, lk_tgl_q};
            sy_s_q <= sy_m_q;
            sy_p_q <= sy_s_q;
        end
    end

    // bus event decode
    wire scl_s     = sy_s_q[2];
    wire scl_p     = sy_p_q[2];
    wire sda_s     = sy_s_q[1];
    wire sda_p     = sy_p_q[1];
    wire start_evt = scl_s && scl_p && !sda_s && sda_p;
    wire stop_evt  = scl_s && scl_p && sda_s && !sda_p;
    wire fall_evt  = !scl_s && scl_p;
    // toggle is seen after the link bit settled; bit stays until next rise
    wire bit_evt   = sy_s_q[0] ^ sy_p_q[0];

    // ---- protocol state
    irs_state_e st_q;
    irs_state_e st_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [7:0] shf_q;
    logic [7:0] shf_d;
    logic [7:0] idx_q;
    logic [7:0] idx_d;
    logic       rw_q;
    logic       rw_d;
    logic       mack_q;
    logic       mack_d;
    logic       oe_b_q;
    logic       oe_b_d;
    logic       busy_q;
    logic       stb_q;
    irs_wr_s    wr_d;
    logic [7:0] rd_data;
    logic [NREG*8-1:0] regs;

    // own address from register eight, upper bits fixed zero
    wire [ADDR_W-1:0] addr_fld = regs[ADDR_REG*8 + ADDR_LSB +: ADDR_W];
    wire [6:0] dev_addr = {3'h0, addr_fld};
    wire       addr_hit = shf_q[7:1] == dev_addr;
    wire       active   = (st_q != ST_IDLE) && (st_q != ST_IGNORE);
    wire       in_byte  = cnt_q < BYTE_BITS;
    wire       at_last  = cnt_q == BYTE_BITS;
    wire       at_ack   = cnt_q == ACK_BIT;

    // next state of the byte engine
    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        shf_d  = shf_q;
        idx_d  = idx_q;
        rw_d   = rw_q;
        mack_d = mack_q;
        oe_b_d = oe_b_q;
        wr_d   = '0;
        if (start_evt) begin
            // new or repeated start: decode address again
            st_d   = ST_ADDR;
            cnt_d  = CNT_RST;
            oe_b_d = 1'b1;
        end else if (stop_evt) begin
            st_d   = ST_IDLE;
            cnt_d  = CNT_RST;
            oe_b_d = 1'b1;
        end else if (!active) begin
            oe_b_d = 1'b1;
        end else begin
            if (bit_evt) begin
                cnt_d = cnt_q + 4'h1;
                if (in_byte && st_q != ST_RDATA) begin
                    shf_d = {shf_q[6:0], lk_bit_q}; // msb first
                end
                if (at_last && st_q == ST_RDATA) begin
                    mack_d = lk_bit_q;
                end
            end
            if (fall_evt) begin
                if (at_last) begin
                    // end of eighth bit: ack window opens
                    case (st_q)
                        ST_ADDR: begin
                            if (addr_hit) begin
                                oe_b_d = 1'b0;
                                rw_d   = shf_q[0];
                            end else begin
                                st_d   = ST_IGNORE;
                                oe_b_d = 1'b1;
                            end
                        end
                        ST_INDEX: begin
                            idx_d  = shf_q;
                            oe_b_d = 1'b0;
                        end
                        ST_WDATA: begin
                            wr_d   = '{en: 1'b1, idx: idx_q, data: shf_q};
                            oe_b_d = 1'b0;
                        end
                        default: begin
                            oe_b_d = 1'b1; // master owns its ack
                        end
                    endcase
                end else if (at_ack) begin
                    // end of ack clock: release, go to next byte
                    cnt_d  = CNT_RST;
                    oe_b_d = 1'b1;
                    case (st_q)
                        ST_ADDR: begin
                            if (rw_q) begin
                                st_d   = ST_RDATA;
                                shf_d  = rd_data;
                                oe_b_d = rd_data[7];
                            end else begin
                                st_d = ST_INDEX;
                            end
                        end
                        ST_INDEX: begin
                            st_d = ST_WDATA;
                        end
                        ST_RDATA: begin
                            if (!mack_q) begin
                                shf_d  = rd_data;
                                oe_b_d = rd_data[7];
                            end else begin
                                st_d = ST_IGNORE;
                            end
                        end
                        default: begin
                            st_d = ST_IGNORE; // one update per write
                        end
                    endcase
                end else if (st_q == ST_RDATA) begin
                    // present the next read bit, release for ones
                    shf_d  = {shf_q[6:0], 1'b0};
                    oe_b_d = shf_q[6];
                end
            end
        end
    end

    // state registers
    always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            st_q   <= ST_IDLE;
            cnt_q  <= CNT_RST;
            shf_q  <= BYTE_RST;
            idx_q  <= BYTE_RST;
            rw_q   <= 1'b0;
            mack_q <= 1'b1;
            oe_b_q <= 1'b1;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            shf_q  <= shf_d;
            idx_q  <= idx_d;
            rw_q   <= rw_d;
            mack_q <= mack_d;
            oe_b_q <= oe_b_d;
        end
    end

    // status outputs, all registered
    always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            busy_q <= 1'b0;
            stb_q  <= 1'b0;
        end else begin
            busy_q <= st_d != ST_IDLE;
            stb_q  <= wr_d.en;
        end
    end

    // register array with factory and otp defaults
    irs_regfile #(
        .DEF  (FACTORY_DEF),
        .MASK (RSVD_MASK)
    ) u_regs (
        .i_clk     (I_CORE_CLK),
        .i_rst_b   (I_RST_B),
        .i_otp_vld (I_OTP_VALID),
        .i_otp_def (I_OTP_DEF),
        .i_wr      (wr_d),
        .i_rd_idx  (idx_q),
        .o_rd_data (rd_data),
        .o_regs    (regs)
    );

    // pin and status drive; the line is only ever pulled low
    assign O_SDA_OUT  = 1'b0;
    assign O_SDA_OE_B = oe_b_q;
    assign O_BUSY     = busy_q;
    assign O_WR_STB   = stb_q;
    assign O_DEV_ADDR = dev_addr;
    assign O_REGS     = regs;

    // ---- checks
    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (!I_RST_B);

    chk_start_addr: assert property (
        start_evt |=> st_q == ST_ADDR && cnt_q == CNT_RST && oe_b_q)
        else $error("start did not restart address decode");

    chk_stop_idle: assert property (
        stop_evt |=> st_q == ST_IDLE && oe_b_q && !O_BUSY ##1 !O_BUSY)
        else $error("stop did not return to idle");

    chk_ack_match: assert property (
        st_q == ST_ADDR && fall_evt && at_last && addr_hit
        && !start_evt && !stop_evt |=> !O_SDA_OE_B)
        else $error("own address not acknowledged");

    chk_foreign_free: assert property (
        st_q == ST_ADDR && fall_evt && at_last && !addr_hit
        && !start_evt && !stop_evt |=> st_q == ST_IGNORE && O_SDA_OE_B)
        else $error("foreign address not ignored");

    chk_ignore_release: assert property (
        st_q == ST_IGNORE || st_q == ST_IDLE |-> O_SDA_OE_B)
        else $error("line driven while idle");

    chk_write_commit: assert property (
        wr_d.en |-> fall_evt && at_last && st_q == ST_WDATA
        ##1 O_WR_STB && (idx_q >= 8'(NREG) || regs[idx_q*8 +: 8] ==
            ($past(shf_q) & RSVD_MASK[idx_q*8 +: 8])))
        else $error("write not committed at last falling edge");

    chk_drive_window: assert property (
        !O_SDA_OE_B |-> st_q == ST_RDATA || cnt_q >= BYTE_BITS)
        else $error("data line driven outside own bits");

    chk_read_msb: assert property (
        st_q == ST_ADDR && st_d == ST_RDATA |=>
        O_SDA_OE_B == rd_data[7] && shf_q == rd_data)
        else $error("read byte does not start with indexed msb");

    chk_addr_range: assert property (
        O_DEV_ADDR[6:4] == 3'h0)
        else $error("device address outside lowest sixteen");

    chk_byte_count: assert property (
        cnt_q <= ACK_BIT)
        else $error("bit counter overran ack slot");

    chk_index_ack: assert property (
        st_q == ST_INDEX && fall_evt && at_last && !start_evt && !stop_evt
        |=> !O_SDA_OE_B && idx_q == $past(shf_q))
        else $error("index byte not taken or not acknowledged");

    chk_read_shift: assert property (
        st_q == ST_RDATA && fall_evt && cnt_q < BYTE_BITS
        && !start_evt && !stop_evt |=> O_SDA_OE_B == shf_q[7])
        else $error("read bit not presented msb first");

    chk_read_release: assert property (
        st_q == ST_RDATA && fall_evt && at_last
        && !start_evt && !stop_evt |=> O_SDA_OE_B)
        else $error("line held during master ack");

    chk_read_repeat: assert property (
        st_q == ST_RDATA && fall_evt && at_ack && !mack_q
        && !start_evt && !stop_evt |=> st_q == ST_RDATA
        && shf_q == $past(rd_data) && O_SDA_OE_B == shf_q[7])
        else $error("acked read did not resend the register");

    chk_strobe_pulse: assert property (
        O_WR_STB |=> !O_WR_STB)
        else $error("write strobe longer than one cycle");

    cov_write: cover property (
        st_q == ST_WDATA && wr_d.en ##[1:300] stop_evt);
    cov_read: cover property (
        st_q == ST_ADDR && st_d == ST_RDATA ##[1:1000] st_q == ST_IGNORE);
    cov_foreign: cover property (
        st_q == ST_ADDR ##1 st_q == ST_IGNORE);
    cov_restart: cover property (
        st_q == ST_WDATA && start_evt);
    cov_repeat: cover property (
        st_q == ST_RDATA && fall_evt && at_ack && !mack_q);
endmodule

// *** irs_pkg_regfile.sv ***
// shared constants, types and the register array of the two-wire slave
`timescale 1ns/1ps
package irs_pkg;
    localparam int          NREG        = 16;
    localparam int          IDX_W       = 4;
    localparam logic [7:0]  ADDR_REG    = 8'h08;
    localparam int          ADDR_LSB    = 0;
    localparam int          ADDR_W      = 4;
    localparam logic [3:0]  BYTE_BITS   = 4'h8;
    localparam logic [3:0]  ACK_BIT     = 4'h9;
    localparam logic [3:0]  CNT_RST     = 4'h0;
    localparam logic [7:0]  BYTE_RST    = 8'h00;
    localparam int          FAST_KHZ    = 400;
    localparam int          CORE_KHZ    = 40000;
    localparam int          OVERSAMPLE  = CORE_KHZ / FAST_KHZ;

    // one-hot protocol states
    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_ADDR   = 6'h02,
        ST_INDEX  = 6'h04,
        ST_WDATA  = 6'h08,
        ST_RDATA  = 6'h10,
        ST_IGNORE = 6'h20
    } irs_state_e;

    // register write request
    typedef struct packed {
        logic       en;
        logic [7:0] idx;
        logic [7:0] data;
    } irs_wr_s;
endpackage

module irs_regfile import irs_pkg::*; #(
    parameter logic [NREG*8-1:0] DEF  = '0,
    parameter logic [NREG*8-1:0] MASK = {NREG{8'hff}}
) (
    input  wire logic              i_clk,
    input  wire logic              i_rst_b,
    input  wire logic              i_otp_vld,
    input  wire logic [NREG*8-1:0] i_otp_def,
    input  wire irs_wr_s           i_wr,
    input  wire logic [7:0]        i_rd_idx,
    output logic [7:0]             o_rd_data,
    output logic [NREG*8-1:0]      o_regs
);
    logic [7:0] reg_q [NREG];
    logic       ld_q;
    wire        rd_hit = i_rd_idx < 8'(NREG);

    // one load window right after reset release
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ld_q <= 1'b1;
        end else begin
            ld_q <= 1'b0;
        end
    end

    // per entry: factory value, then otp page, then bus writes
    for (genvar g = 0; g < NREG; g++) begin : g_reg
        wire [7:0] msk = MASK[g*8 +: 8];
        wire       hit = i_wr.en && (i_wr.idx == 8'(g));
        always_ff @(posedge i_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
                reg_q[g] <= DEF[g*8 +: 8] & MASK[g*8 +: 8];
            end else if (ld_q && i_otp_vld) begin
                reg_q[g] <= i_otp_def[g*8 +: 8] & msk;
            end else if (hit) begin
                reg_q[g] <= i_wr.data & msk;
            end
        end
        assign o_regs[g*8 +: 8] = reg_q[g];

        chk_rsvd_zero: assert property (
            @(posedge i_clk) disable iff (!i_rst_b)
            (reg_q[g] & ~msk) == 8'h00)
            else $error("reserved bit set");
    end

    // unmapped index reads zero
    assign o_rd_data = rd_hit ? reg_q[i_rd_idx[IDX_W-1:0]] : BYTE_RST;

    chk_otp_load: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        ld_q && i_otp_vld |=> o_regs == ($past(i_otp_def) & MASK))
        else $error("otp defaults not loaded");
endmodule

// *** irs_master.sv ***
`timescale 1ns/1ps
// fast-mode bus master: drives the clock and its open-drain data share
module irs_master (
    input  wire logic i_clk,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda
);
    localparam int Q = 26; // quarter bit, gives 1.3 us low and high

    // both lines idle high; the clock stands still outside frames
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end

    // lines move only just after a core falling edge
    task automatic wt(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    // start or repeated start: data falls while the clock is high
    task automatic start();
        o_sda = 1'b1;
        wt(Q);
        o_scl = 1'b1;
        wt(Q);
        o_sda = 1'b0;
        wt(Q);
        o_scl = 1'b0;
        wt(Q);
    endtask

    // stop: data rises while the clock is high, then all idles
    task automatic stop();
        o_sda = 1'b0;
        wt(Q);
        o_scl = 1'b1;
        wt(Q);
        o_sda = 1'b1;
        wt(Q);
    endtask

    // one clock pulse; data set mid-low, wire sampled mid-high
    task automatic bit_io(input logic b, output logic s);
        o_sda = b;
        wt(Q);
        o_scl = 1'b1;
        wt(Q);
        s = i_sda;
        wt(Q);
        o_scl = 1'b0;
        wt(Q);
    endtask

    // eight bits msb first, then releases for the ack pulse
    task automatic send(input logic [7:0] d, output logic ack,
                        output logic clash);
        logic s;
        clash = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
            clash |= (s !== d[i]);
        end
        bit_io(1'b1, ack);
    endtask

    // eight bits from the device, then the master's ack or nack
    task automatic recv(input logic mack, output logic [7:0] d,
                        output logic rel);
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(mack, rel);
    endtask
endmodule

// *** test_i2c_register_slave.sv ***
`timescale 1ns/1ps
module test_i2c_register_slave import irs_pkg::*;;
    localparam logic [NREG*8-1:0] MSK = {{12{8'hff}}, 8'h3f, {3{8'hff}}};
    localparam logic [NREG*8-1:0] FAC = {16{8'h5a}};
    localparam logic [NREG*8-1:0] OTP = {{7{8'ha5}}, 8'h05, {8{8'ha5}}};

    logic              clk = 1'b0;
    logic              rst_b = 1'b0;
    logic              otp_vld = 1'b1;
    logic              scl;
    logic              m_sda;
    logic              sda_w;
    logic              sda_out;
    logic              oe_b;
    logic              busy;
    logic              wr_stb;
    logic [6:0]        dev_addr;
    logic [NREG*8-1:0] regs;
    int                fails = 0;
    int                samples_checked = 0;
    int                stb_cnt = 0;

    // wired-and data line with pull-up
    assign sda_w = m_sda & (oe_b ? 1'b1 : sda_out);

    always #12.5 clk = ~clk;

    // count write strobes away from the edge that launches them
    always @(negedge clk) if (wr_stb === 1'b1) stb_cnt++;

    irs_slave #(
        .FACTORY_DEF (FAC),
        .RSVD_MASK   (MSK)
    ) uut (
        .I_CORE_CLK  (clk),
        .I_RST_B     (rst_b),
        .I_SCL       (scl),
        .I_SDA       (sda_w),
        .I_OTP_VALID (otp_vld),
        .I_OTP_DEF   (OTP),
        .O_SDA_OUT   (sda_out),
        .O_SDA_OE_B  (oe_b),
        .O_BUSY      (busy),
        .O_WR_STB    (wr_stb),
        .O_DEV_ADDR  (dev_addr),
        .O_REGS      (regs)
    );

    irs_master mst (
        .i_clk (clk),
        .i_sda (sda_w),
        .o_scl (scl),
        .o_sda (m_sda)
    );

    task automatic results();
        if (fails == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // comparisons by kind
    task automatic chk_bit(input logic g, e);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %0t bit got %b exp %b", $time, g, e);
        end
    endtask

    task automatic chk_byte(input logic [7:0] g, e);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %0t byte got %h exp %h", $time, g, e);
        end
    endtask

    task automatic chk_regs(input logic [NREG*8-1:0] g, e);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %0t regs got %h exp %h", $time, g, e);
        end
    endtask

    task automatic do_reset(input logic otp);
        rst_b = 1'b0;
        otp_vld = otp;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        repeat (6) @(negedge clk);
    endtask

    // single-byte write; nk is the expected ack level of every byte
    task automatic wr(input logic [6:0] a, input logic [7:0] i, d,
                      input logic nk);
        logic k, c, cl;
        int   n0;
        n0 = stb_cnt;
        mst.start();
        chk_bit(busy, 1'b1);
        mst.send({a, 1'b0}, k, cl);
        chk_bit(k, nk);
        mst.send(i, k, c);
        cl |= c;
        chk_bit(k, nk);
        mst.send(d, k, c);
        cl |= c;
        chk_bit(k, nk);
        chk_bit(cl, 1'b0);
        mst.stop();
        chk_bit(busy, 1'b0);
        chk_bit(oe_b, 1'b1);
        chk_bit(sda_out, 1'b0);
        chk_byte(8'(stb_cnt - n0), {7'h00, ~nk});
        if (!nk && i < 8'h10)
            chk_byte(regs[i[3:0]*8 +: 8], d & MSK[i[3:0]*8 +: 8]);
    endtask

    // index phase to a, repeated start, read phase to b
    task automatic rd(input logic [6:0] a, b, input logic [7:0] i, ex,
                      input logic na, nb);
        logic       k, c, r;
        logic [7:0] g;
        mst.start();
        mst.send({a, 1'b0}, k, c);
        chk_bit(k, na);
        mst.send(i, k, c);
        chk_bit(k, na);
        mst.start();
        mst.send({b, 1'b1}, k, c);
        chk_bit(k, nb);
        mst.recv(1'b1, g, r);
        chk_byte(g, ex);
        chk_bit(r, 1'b1);
        mst.stop();
    endtask

    task automatic s_otp();
        do_reset(1'b1);
        chk_regs(regs, OTP & MSK);
        chk_byte({1'b0, dev_addr}, 8'h05);
    endtask

    task automatic s_rw();
        wr(7'h05, 8'h03, 8'hff, 1'b0);
        rd(7'h05, 7'h05, 8'h03, 8'h3f, 1'b0, 1'b0);
        wr(7'h05, 8'h04, 8'h81, 1'b0);
        rd(7'h05, 7'h05, 8'h04, 8'h81, 1'b0, 1'b0);
    endtask

    task automatic s_foreign();
        wr(7'h06, 8'h02, 8'h11, 1'b1);
        chk_byte(regs[23:16], 8'ha5);
        rd(7'h05, 7'h06, 8'h02, 8'hff, 1'b0, 1'b1);
        rd(7'h15, 7'h15, 8'h02, 8'hff, 1'b1, 1'b1);
    endtask

    // a second data byte is refused and not stored
    task automatic s_extra();
        logic k, c;
        int   n0;
        n0 = stb_cnt;
        mst.start();
        mst.send({7'h05, 1'b0}, k, c);
        mst.send(8'h01, k, c);
        mst.send(8'h22, k, c);
        mst.send(8'h33, k, c);
        chk_bit(k, 1'b1);
        mst.stop();
        chk_byte(regs[15:8], 8'h22);
        chk_byte(8'(stb_cnt - n0), 8'h01);
    endtask

    // move the own address to both ends of its range
    task automatic s_addr();
        wr(7'h05, 8'h08, 8'h0f, 1'b0);
        chk_byte({1'b0, dev_addr}, 8'h0f);
        wr(7'h05, 8'h02, 8'h11, 1'b1);
        rd(7'h0f, 7'h0f, 8'h08, 8'h0f, 1'b0, 1'b0);
        wr(7'h0f, 8'h08, 8'h00, 1'b0);
        rd(7'h00, 7'h00, 8'h20, 8'h00, 1'b0, 1'b0);
    endtask

    // mid-run reset without an otp page
    task automatic s_factory();
        do_reset(1'b0);
        chk_regs(regs, FAC & MSK);
        chk_byte({1'b0, dev_addr}, 8'h0a);
        rd(7'h0a, 7'h0a, 8'h03, 8'h1a, 1'b0, 1'b0);
        wr(7'h0a, 8'h03, 8'h2c, 1'b0);
    endtask

    // master acks the read byte: the same register comes again
    task automatic s_repeat();
        logic       k, c, r;
        logic [7:0] g;
        mst.start();
        mst.send({7'h0a, 1'b0}, k, c);
        mst.send(8'h03, k, c);
        mst.start();
        mst.send({7'h0a, 1'b1}, k, c);
        chk_bit(k, 1'b0);
        mst.recv(1'b0, g, r);
        chk_byte(g, 8'h2c);
        chk_bit(r, 1'b0);
        mst.recv(1'b1, g, r);
        chk_byte(g, 8'h2c);
        mst.stop();
        chk_bit(busy, 1'b0);
    endtask

    initial begin
        s_otp();
        s_rw();
        s_foreign();
        s_extra();
        s_addr();
        s_factory();
        s_repeat();
        results();
    end

    // hang guard
    initial begin
        repeat (95000) @(posedge clk);
        fails++;
        $display("[ERR] %0t run limit reached", $time);
        results();
    end
endmodule
